/* rtl/deflection_cfg.svh */
/*
 * Constants of the deflection controller write port: slave address,
 * subaddresses, control bit positions and reset values.
 * Assumes it is included by bare name wherever these values are needed.
 */
`ifndef DEFLECTION_CFG_SVH
`define DEFLECTION_CFG_SVH

// ----------------------------------------------------------------------
// bus framing
// ----------------------------------------------------------------------
`define SLAVE_ADDR_BYTE        8'h8c
`define SUBADDR_MODE_BIT       7
`define BYTE_LAST_BIT          4'h7
`define ACK_CLOCK_CNT          4'h8
`define ACK_DONE_CNT           4'h9

// ----------------------------------------------------------------------
// register subaddresses (direct-mode values; the two moire values carry the mode bit)
// ----------------------------------------------------------------------
`define CORNER_CENTRE_OFS      7'h02
`define LOOP_CORRECTION_OFS    7'h04
`define CLAMP_BLANK_LEN_OFS    7'h09
`define BLANKING_SELECT_OFS    7'h0a
`define VERT_GAIN_TRACK_OFS    7'h0b
`define OVERSCAN_OFS           7'h0f
`define POWER_SEQUENCE_OFS     7'h1a
`define MOIRE_OFS              8'h80
`define MOIRE_ALT_OFS          8'h88

// ----------------------------------------------------------------------
// register slots inside the bank
// ----------------------------------------------------------------------
`define SLOT_CORNER            3'h0
`define SLOT_LOOP              3'h1
`define SLOT_CLAMP             3'h2
`define SLOT_BLANK_SEL         3'h3
`define SLOT_GAIN_TRACK        3'h4
`define SLOT_OVERSCAN          3'h5
`define SLOT_POWER             3'h6
`define SLOT_MOIRE             3'h7

// ----------------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------------
`define BIT_SHAPE_CENTRE       6
`define BIT_LOOP_LINK          6
`define BIT_CLAMP_EDGE         6
`define BIT_BLANK_LEN          7
`define BIT_UNLOCK_OMIT        6
`define BIT_GAIN_OFF           6
`define BIT_FREQ_TRACK         7
`define BIT_OVERSCAN           6
`define BIT_POWER_DOWN         0
`define BIT_RAMP_RELEASE       1
`define BIT_MOIRE_OFF          7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CTRL_RST_VAL           8'h00
`define POWER_RST_VAL          8'h01

`endif

/* rtl/deflection_pkg.sv */
/*
 * Types shared by the deflection controller write port.
 * Assumes nothing of its surroundings.
 */
package deflection_pkg;

    // gray coded along idle -> address -> subaddress -> data
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_SUB  = 3'h3,
        ST_DATA = 3'h2,
        ST_SKIP = 3'h6
    } xfer_state_e;

    typedef logic [7:0] byte_t;

endpackage

/* rtl/pin_sync.sv */
/*
 * Three-stage synchroniser per bit; the output follows once the second
 * and third stages agree.
 * Assumes inputs are asynchronous to sys_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk_i) begin
            s1_reg[i] <= async_i[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
            if (srst_i) begin
                level_o[i] <= 1'b1;
            end else if (s2_reg[i] == s3_reg[i]) begin
                level_o[i] <= s3_reg[i];
            end
        end
    end

endmodule

`default_nettype wire

/* rtl/link_shifter.sv */
/*
 * Serial data shifter clocked by the bus clock itself.
 * Assumes the system side reads byte_o only between the eighth and ninth
 * rising edges of the bus clock, when it cannot change.
 */
`timescale 1ns/100ps
`default_nettype none

module link_shifter (
    // link clock and data
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    // shifted byte
    output var  deflection_pkg::byte_t byte_o
);
    import deflection_pkg::*;

    // no reset: the clock stands still outside frames, and the system
    // side only trusts the byte after eight fresh edges
    always_ff @(posedge scl_i) begin
        byte_o <= {byte_o[6:0], sda_i};
    end

endmodule

`default_nettype wire

/* rtl/deflection_write_port.sv */
/*
 * Write-only serial slave port of a monitor deflection controller and
 * its control switch register bank.
 * Assumes a bus clock well below sys_clk_i/8, a vertical blanking pulse
 * and protection clear from logic on sys_clk_i, and an open-drain data
 * wire resolved outside.
 */
`timescale 1ns/100ps
`default_nettype none

`include "deflection_cfg.svh"

module deflection_write_port (
    // system clock and reset
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    // serial bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var  logic sda_o,
    output var  logic sda_oe_o,
    // internal status from the analog side
    input  wire logic supply_ok_i,
    input  wire logic internal_vert_blank_pulse_i,
    input  wire logic prot_clear_i,
    input  wire logic vert_blank_i,
    input  wire logic prot_blank_i,
    input  wire logic unlock_blank_i,
    // blanking outputs
    output var  logic composite_blank_out_o,
    output var  logic horiz_lock_loss_out_o,
    // decoded control switches
    output var  logic unlock_blank_omit_o,
    output var  logic vert_gain_ctrl_off_o,
    output var  logic ew_freq_tracking_o,
    output var  logic shape_centre_force_o,
    output var  logic moire_cancel_off_o,
    output var  logic vert_overscan_sel_o,
    output var  logic clamp_lead_edge_o,
    output var  logic vert_blank_len_sel_o,
    output var  logic loop_correction_link_o,
    output var  logic power_down_sel_o,
    output var  logic ramp_release_o,
    // port status
    output var  logic buffer_locked_o
);
    import deflection_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisation and link shifter
    // ------------------------------------------------------------------
    logic        scl_lvl;
    logic        sda_lvl;
    logic        scl_d_reg;
    logic        sda_d_reg;
    logic        supply_lvl;
    byte_t       link_byte;

    pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .async_i   ({supply_ok_i, sda_i, scl_i}),
        .level_o   ({supply_lvl, sda_lvl, scl_lvl})
    );

    link_shifter u_shift (
        .scl_i  (scl_i),
        .sda_i  (sda_i),
        .byte_o (link_byte)
    );

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_lvl;
            sda_d_reg <= sda_lvl;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise   = scl_lvl & ~scl_d_reg;
    assign scl_fall   = ~scl_lvl & scl_d_reg;
    assign start_cond = scl_lvl & scl_d_reg & sda_d_reg & ~sda_lvl;
    assign stop_cond  = scl_lvl & scl_d_reg & ~sda_d_reg & sda_lvl;

    // ------------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------------
    xfer_state_e state_reg;
    xfer_state_e after_ack_reg;
    logic [3:0]  bit_cnt_reg;
    logic        ack_ok_reg;
    logic        data_seen_reg;
    logic        buffered_reg;
    logic [6:0]  sub_idx_reg;
    byte_t       data_reg;
    logic        lock_reg;
    logic        byte_done;

    // the byte is sampled after the synchronised eighth rising edge; the
    // shifter cannot move again until the ninth edge, microseconds later
    assign byte_done = scl_rise && (bit_cnt_reg == `BYTE_LAST_BIT);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (start_cond) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
        end else if (stop_cond) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (state_reg != ST_IDLE) begin
            if (scl_rise && bit_cnt_reg != `ACK_DONE_CNT) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `ACK_DONE_CNT) begin
                bit_cnt_reg <= 4'h0;
                state_reg   <= after_ack_reg;
            end
        end
    end

    // acknowledge decision for each completed byte
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || start_cond) begin
            ack_ok_reg    <= 1'b0;
            after_ack_reg <= ST_SKIP;
            data_seen_reg <= 1'b0;
            buffered_reg  <= 1'b0;
            sub_idx_reg   <= 7'h00;
            data_reg      <= 8'h00;
        end else if (byte_done) begin
            case (state_reg)
                ST_ADDR: begin
                    // read requests and foreign addresses are left alone
                    ack_ok_reg    <= (link_byte == `SLAVE_ADDR_BYTE)
                                     && supply_lvl
                                     && !lock_reg;
                    after_ack_reg <= ((link_byte == `SLAVE_ADDR_BYTE) && supply_lvl
                                     && !lock_reg) ? ST_SUB : ST_SKIP;
                end
                ST_SUB: begin
                    ack_ok_reg    <= supply_lvl &&
                                     !(link_byte[`SUBADDR_MODE_BIT] && power_down_sel_o);
                    after_ack_reg <= (supply_lvl &&
                                     !(link_byte[`SUBADDR_MODE_BIT] && power_down_sel_o))
                                     ? ST_DATA : ST_SKIP;
                    buffered_reg  <= link_byte[`SUBADDR_MODE_BIT];
                    sub_idx_reg   <= link_byte[6:0];
                end
                ST_DATA: begin
                    // extra bytes rewrite the same register, never the next
                    // one; a buffered transfer takes a single byte
                    if (supply_lvl && !(buffered_reg && data_seen_reg)) begin
                        ack_ok_reg    <= 1'b1;
                        data_reg      <= link_byte;
                        data_seen_reg <= 1'b1;
                    end else begin
                        ack_ok_reg    <= 1'b0;
                    end
                    after_ack_reg <= ST_DATA;
                end
                default: begin
                    ack_ok_reg    <= 1'b0;
                    after_ack_reg <= ST_SKIP;
                end
            endcase
        end
    end

    // open-drain acknowledge: pull low from the eighth fall to the ninth
    always_ff @(posedge sys_clk_i) begin
        sda_o <= 1'b0;
        if (srst_i || start_cond || stop_cond) begin
            sda_oe_o <= 1'b0;
        end else if (scl_fall && bit_cnt_reg == `ACK_CLOCK_CNT) begin
            sda_oe_o <= ack_ok_reg && (state_reg != ST_SKIP) && supply_lvl;
        end else if (scl_fall && bit_cnt_reg == `ACK_DONE_CNT) begin
            sda_oe_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // commit: direct at stop, buffered at the next blanking pulse
    // ------------------------------------------------------------------
    logic       commit;
    logic       dir_we_reg;
    logic [6:0] dir_idx_reg;
    byte_t      dir_data_reg;
    logic       pend_valid_reg;
    logic [6:0] pend_idx_reg;
    byte_t      pend_data_reg;
    logic       vbl_apply;

    assign commit    = stop_cond && (state_reg == ST_DATA) && data_seen_reg;
    assign vbl_apply = internal_vert_blank_pulse_i && pend_valid_reg;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dir_we_reg   <= 1'b0;
            dir_idx_reg  <= 7'h00;
            dir_data_reg <= 8'h00;
        end else begin
            dir_we_reg <= commit && !buffered_reg;
            if (commit && !buffered_reg) begin
                dir_idx_reg  <= sub_idx_reg;
                dir_data_reg <= data_reg;
            end
        end
    end

    // a stop in the same cycle as a pulse waits for the following pulse
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pend_valid_reg <= 1'b0;
            pend_idx_reg   <= 7'h00;
            pend_data_reg  <= 8'h00;
        end else if (commit && buffered_reg) begin
            pend_valid_reg <= 1'b1;
            pend_idx_reg   <= sub_idx_reg;
            pend_data_reg  <= data_reg;
        end else if (vbl_apply) begin
            pend_valid_reg <= 1'b0;
        end
    end

    // set wins over the clearing pulse
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            lock_reg <= 1'b0;
        end else if (commit && buffered_reg) begin
            lock_reg <= 1'b1;
        end else if (internal_vert_blank_pulse_i) begin
            lock_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------------
    function automatic logic [3:0] slot_of(input logic [6:0] idx);
        case (idx)
            `CORNER_CENTRE_OFS:   slot_of = {1'b1, `SLOT_CORNER};
            `LOOP_CORRECTION_OFS: slot_of = {1'b1, `SLOT_LOOP};
            `CLAMP_BLANK_LEN_OFS: slot_of = {1'b1, `SLOT_CLAMP};
            `BLANKING_SELECT_OFS: slot_of = {1'b1, `SLOT_BLANK_SEL};
            `VERT_GAIN_TRACK_OFS: slot_of = {1'b1, `SLOT_GAIN_TRACK};
            `OVERSCAN_OFS:        slot_of = {1'b1, `SLOT_OVERSCAN};
            `POWER_SEQUENCE_OFS:  slot_of = {1'b1, `SLOT_POWER};
            // the cast drops the mode bit on purpose: both forms share a slot
            7'(`MOIRE_OFS),
            7'(`MOIRE_ALT_OFS):   slot_of = {1'b1, `SLOT_MOIRE};
            default:              slot_of = 4'h0;
        endcase
    endfunction

    logic [3:0] dir_slot;
    logic [3:0] pend_slot;
    byte_t      ctrl_reg [0:7];

    localparam byte_t POWER_RST = `POWER_RST_VAL;

    assign dir_slot  = slot_of(dir_idx_reg);
    assign pend_slot = slot_of(pend_idx_reg);

    for (genvar s = 0; s < 8; s++) begin : g_slot
        always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
                ctrl_reg[s] <= (s == `SLOT_POWER) ? `POWER_RST_VAL : `CTRL_RST_VAL;
            end else if (vbl_apply && pend_slot == {1'b1, 3'(s)}) begin
                ctrl_reg[s] <= pend_data_reg;
            end else if (dir_we_reg && dir_slot == {1'b1, 3'(s)}) begin
                ctrl_reg[s] <= dir_data_reg;
            end
            if (!srst_i && s == `SLOT_POWER && prot_clear_i) begin
                ctrl_reg[s][`BIT_POWER_DOWN]   <= POWER_RST[`BIT_POWER_DOWN];
                ctrl_reg[s][`BIT_RAMP_RELEASE] <= POWER_RST[`BIT_RAMP_RELEASE];
            end
        end
    end

    // ------------------------------------------------------------------
    // decoded outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            composite_blank_out_o <= 1'b1;
            horiz_lock_loss_out_o <= 1'b1;
        end else begin
            composite_blank_out_o <= vert_blank_i | prot_blank_i |
                (unlock_blank_i & ~ctrl_reg[`SLOT_BLANK_SEL][`BIT_UNLOCK_OMIT]);
            horiz_lock_loss_out_o <= vert_blank_i | prot_blank_i |
                (unlock_blank_i & ~ctrl_reg[`SLOT_BLANK_SEL][`BIT_UNLOCK_OMIT]);
        end
    end

    always_comb begin
        unlock_blank_omit_o    = ctrl_reg[`SLOT_BLANK_SEL][`BIT_UNLOCK_OMIT];
        vert_gain_ctrl_off_o   = ctrl_reg[`SLOT_GAIN_TRACK][`BIT_GAIN_OFF];
        ew_freq_tracking_o     = ctrl_reg[`SLOT_GAIN_TRACK][`BIT_FREQ_TRACK];
        shape_centre_force_o   = ctrl_reg[`SLOT_CORNER][`BIT_SHAPE_CENTRE];
        moire_cancel_off_o     = ctrl_reg[`SLOT_MOIRE][`BIT_MOIRE_OFF];
        vert_overscan_sel_o    = ctrl_reg[`SLOT_OVERSCAN][`BIT_OVERSCAN];
        clamp_lead_edge_o      = ctrl_reg[`SLOT_CLAMP][`BIT_CLAMP_EDGE];
        vert_blank_len_sel_o   = ctrl_reg[`SLOT_CLAMP][`BIT_BLANK_LEN];
        loop_correction_link_o = ctrl_reg[`SLOT_LOOP][`BIT_LOOP_LINK];
        power_down_sel_o       = ctrl_reg[`SLOT_POWER][`BIT_POWER_DOWN];
        ramp_release_o         = ctrl_reg[`SLOT_POWER][`BIT_RAMP_RELEASE];
        buffer_locked_o        = lock_reg;
    end

endmodule

`default_nettype wire

/* tb/deflection_write_port_monitor.sv */
/*
 * Assertion checker for the deflection controller write port.
 * Assumes it is bound to deflection_write_port and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module deflection_write_port_monitor (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    // inputs watched
    input  wire logic supply_ok_i,
    input  wire logic internal_vert_blank_pulse_i,
    input  wire logic prot_clear_i,
    input  wire logic vert_blank_i,
    input  wire logic prot_blank_i,
    input  wire logic unlock_blank_i,
    // outputs watched
    input  wire logic sda_o,
    input  wire logic sda_oe_o,
    input  wire logic composite_blank_out_o,
    input  wire logic horiz_lock_loss_out_o,
    input  wire logic unlock_blank_omit_o,
    input  wire logic power_down_sel_o,
    input  wire logic ramp_release_o,
    input  wire logic buffer_locked_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------------
    // blanking and bus pins
    // ------------------------------------------------------------------
    chk_blank_comp: assert property (
        !$past(srst_i) |-> composite_blank_out_o == $past(vert_blank_i | prot_blank_i
            | (unlock_blank_i & ~unlock_blank_omit_o)))
        else $error("composite blank differs from its sources");
    chk_lock_loss: assert property (
        !$past(srst_i) |-> horiz_lock_loss_out_o == $past(vert_blank_i | prot_blank_i
            | (unlock_blank_i & ~unlock_blank_omit_o)))
        else $error("lock loss output differs from its sources");
    chk_sda_value: assert property (!sda_o)
        else $error("data pin driven high");
    // supply has to be good well before an acknowledge starts
    chk_ack_supply: assert property ($rose(sda_oe_o) |-> $past(supply_ok_i, 6))
        else $error("acknowledge with supply low");

    // ------------------------------------------------------------------
    // buffered lock and protection
    // ------------------------------------------------------------------
    chk_prot_clear: assert property (
        prot_clear_i |=> power_down_sel_o && !ramp_release_o)
        else $error("protection clear ignored");
    chk_lock_release: assert property (
        buffer_locked_o && internal_vert_blank_pulse_i |=> !buffer_locked_o)
        else $error("lock kept past blanking pulse");
    chk_lock_hold: assert property (
        buffer_locked_o && !internal_vert_blank_pulse_i |=> buffer_locked_o)
        else $error("lock dropped without blanking pulse");
    chk_ack_locked: assert property ($rose(sda_oe_o) |-> !buffer_locked_o)
        else $error("acknowledge while locked");
endmodule

`default_nettype wire

/* tb/bus_master_model.sv */
/*
 * Behavioural bus master that writes the port's registers.
 * Assumes sda_i is the resolved wire with a pull-up and that frames
 * start only from an idle bus.
 */
`timescale 1ns/100ps
`default_nettype none

module bus_master_model (
    // timing reference
    input  wire logic clk_i,
    // bus pins
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    import deflection_pkg::*;

    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // quarter bit of 80 ns keeps the bus clock at sys_clk/32, far below sys_clk/8
    task automatic q();
        repeat (8) @(negedge clk_i);
    endtask

    // data changes only while the clock is low
    task automatic clk_bit(input logic b, output logic seen);
        sda_low_o = ~b;
        q();
        scl_o = 1'b1;
        q();
        seen = sda_i;
        q();
        scl_o = 1'b0;
        q();
    endtask

    task automatic start();
        sda_low_o = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask

    task automatic stop();
        sda_low_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_low_o = 1'b0;
        q();
        q();
    endtask

    // msb first, then the ninth clock reads the acknowledge
    task automatic send(input byte_t b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], seen);
        end
        clk_bit(1'b1, seen);
        ack = ~seen;
    endtask
endmodule

`default_nettype wire

/* tb/deflection_write_port_test.sv */
/*
 * Self-checking bench for the deflection controller write port.
 * Assumes the bus master model and the checker are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module deflection_write_port_test;
    import deflection_pkg::*;

    logic sys_clk_i, scl_i, sda_i, m_low, sda_o, sda_oe_o, buffer_locked_o;
    logic srst_i = 1'b1, supply_ok_i = 1'b1, internal_vert_blank_pulse_i = 1'b0;
    logic prot_clear_i = 1'b0, vert_blank_i = 1'b0, prot_blank_i = 1'b0;
    logic unlock_blank_i = 1'b1, composite_blank_out_o, horiz_lock_loss_out_o;
    logic unlock_blank_omit_o, vert_gain_ctrl_off_o, ew_freq_tracking_o, ramp_release_o;
    logic shape_centre_force_o, moire_cancel_off_o, vert_overscan_sel_o, power_down_sel_o;
    logic clamp_lead_edge_o, vert_blank_len_sel_o, loop_correction_link_o;
    logic [10:0] sw;
    logic [3:0] mb_ack;
    int err_count = 0;
    int cmp_count = 0;
    // sub, data, expected switches; each step builds on the one before
    logic [26:0] tbl [9] = '{{8'h1a, 8'h00, 11'h000}, {8'h1a, 8'h02, 11'h001},
        {8'h0a, 8'h40, 11'h401}, {8'h0b, 8'hc0, 11'h701}, {8'h02, 8'h40, 11'h781},
        {8'h08, 8'h80, 11'h7c1}, {8'h0f, 8'h40, 11'h7e1}, {8'h09, 8'hc0, 11'h7f9},
        {8'h04, 8'h40, 11'h7fd}};

    // open-drain wire with pull-up
    assign sda_i = ~(m_low | (sda_oe_o & ~sda_o));
    assign sw = {unlock_blank_omit_o, vert_gain_ctrl_off_o, ew_freq_tracking_o,
        shape_centre_force_o, moire_cancel_off_o, vert_overscan_sel_o, clamp_lead_edge_o,
        vert_blank_len_sel_o, loop_correction_link_o, power_down_sel_o, ramp_release_o};

    deflection_write_port uut (.sys_clk_i, .srst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
        .supply_ok_i, .internal_vert_blank_pulse_i, .prot_clear_i, .vert_blank_i,
        .prot_blank_i, .unlock_blank_i, .composite_blank_out_o, .horiz_lock_loss_out_o,
        .unlock_blank_omit_o, .vert_gain_ctrl_off_o, .ew_freq_tracking_o,
        .shape_centre_force_o, .moire_cancel_off_o, .vert_overscan_sel_o,
        .clamp_lead_edge_o, .vert_blank_len_sel_o, .loop_correction_link_o,
        .power_down_sel_o, .ramp_release_o, .buffer_locked_o);
    bus_master_model m (.clk_i(sys_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(m_low));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // acknowledges packed as address, subaddress, data
    task automatic wr(input byte_t a, input byte_t s, input byte_t d, input logic [2:0] exp);
        logic [2:0] ack;
        m.start();
        m.send(a, ack[2]);
        m.send(s, ack[1]);
        m.send(d, ack[0]);
        m.stop();
        repeat (4) @(negedge sys_clk_i);
        check({8'h00, ack}, {8'h00, exp});
    endtask

    task automatic pulse_vbl();
        internal_vert_blank_pulse_i = 1'b1;
        @(negedge sys_clk_i);
        internal_vert_blank_pulse_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // no wait below is open-ended; this only guards against a stuck run
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        check(sw, 11'h002);
        supply_ok_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        wr(8'h8c, 8'h1a, 8'h00, 3'h0);
        supply_ok_i = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        wr(8'h8d, 8'h1a, 8'h00, 3'h0);
        wr(8'h8e, 8'h1a, 8'h00, 3'h0);
        check(sw, 11'h002);
        for (int i = 0; i < 9; i++) begin
            wr(8'h8c, tbl[i][26:19], tbl[i][18:11], 3'h7);
            check(sw, tbl[i][10:0]);
        end
        check({9'h000, composite_blank_out_o, horiz_lock_loss_out_o}, 11'h000);
        vert_blank_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check({9'h000, composite_blank_out_o, horiz_lock_loss_out_o}, 11'h003);
        vert_blank_i = 1'b0;
        prot_blank_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check({9'h000, composite_blank_out_o, horiz_lock_loss_out_o}, 11'h003);
        prot_blank_i = 1'b0;
        // second data byte must land on the same register, never on 0b
        m.start();
        m.send(8'h8c, mb_ack[3]);
        m.send(8'h0a, mb_ack[2]);
        m.send(8'h00, mb_ack[1]);
        m.send(8'h00, mb_ack[0]);
        m.stop();
        repeat (4) @(negedge sys_clk_i);
        check({7'h00, mb_ack}, 11'h00f);
        check(sw, 11'h3fd);
        check({9'h000, composite_blank_out_o, horiz_lock_loss_out_o}, 11'h003);
        wr(8'h8c, 8'h82, 8'h00, 3'h7);
        check(sw, 11'h3fd);
        check({10'h000, buffer_locked_o}, 11'h001);
        wr(8'h8c, 8'h0f, 8'h00, 3'h0);
        pulse_vbl();
        check(sw, 11'h37d);
        check({10'h000, buffer_locked_o}, 11'h000);
        wr(8'h8c, 8'h1a, 8'h01, 3'h7);
        wr(8'h8c, 8'h8f, 8'h00, 3'h4);
        check(sw, 11'h37e);
        wr(8'h8c, 8'h1a, 8'h02, 3'h7);
        check(sw, 11'h37d);
        prot_clear_i = 1'b1;
        @(negedge sys_clk_i);
        prot_clear_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        check(sw, 11'h37e);
        give_verdict();
    end
endmodule

bind deflection_write_port deflection_write_port_monitor chk (.sys_clk_i, .srst_i,
    .supply_ok_i, .internal_vert_blank_pulse_i, .prot_clear_i, .vert_blank_i,
    .prot_blank_i, .unlock_blank_i, .sda_o, .sda_oe_o, .composite_blank_out_o,
    .horiz_lock_loss_out_o, .unlock_blank_omit_o, .power_down_sel_o, .ramp_release_o,
    .buffer_locked_o);

`default_nettype wire
